// *** rtl/hibernate_state_control.sv ***
// hibernate state control: control register, hibernate pin levels and wake sequencing
// Overview of operation
// - bit 15 selects active (0) or hibernate (1); reset and wake clear it.
// - in hibernate bit 7 low disables watchdog, high lets mode field govern it.
// - on wake, bit 6 high runs startup sequence, low goes straight to active.
// - on wake, bit 5 low pulses internal register reset, high keeps registers.
// - in hibernate bit 4 sets system reset output level, 0 low, 1 high.
// - in hibernate bit 3 high forces interrupt output inactive, low passes it.
// - in hibernate bit 2 sets memory reset output level, 0 low, 1 high.
// - bit 1 high keeps hysteresis comparator on in hibernate, low leaves it off.
// - bit 0 high keeps temperature monitoring on in hibernate, low turns it off.
// - watchdog mode 00 off, 01 interrupt, 10 reset, 11 interrupt then reset.
`timescale 1ns/100ps
`default_nettype none
module hibernate_state_control (
  input wire logic CLK,
  input wire logic RST_N,
  input wire sleep_ctrl_pkg::reg_req_t REG_REQ,
  output logic [15:0] REG_RDATA,
  input wire sleep_ctrl_pkg::watchdog_mode_t WATCHDOG_ACTION_SELECT,
  input wire logic WATCHDOG_EXPIRE,
  input wire logic WAKE_REQUEST,
  input wire logic IRQ_PENDING_N,
  input wire logic SYSRESET_ACTIVE_N,
  input wire logic MEMORY_RESET_ACTIVE_N,
  output logic HIBERNATING,
  output logic STARTUP_BUSY,
  output logic REG_CLEAR,
  output logic SYSRESET_OUT_N,
  output logic MEMORY_RESET_OUT_N,
  output logic IRQ_OUT_N,
  output logic COMPARATOR_ENABLE,
  output logic THERMAL_ENABLE,
  output logic WATCHDOG_EXPIRY_EVENT,
  output logic WATCHDOG_RESET_EVENT
);
  import sleep_ctrl_pkg::*;

  // ==========================================================
  // state machine
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h1,
    ST_SLEEP = 3'h2,
    ST_STARTUP = 3'h4
  } power_state_t;

  power_state_t state_r;
  power_state_t state_nxt;
  logic hibernate_r;
  sleep_cfg_t cfg_r;
  logic [7:0] startup_cnt_r;
  logic [3:0] clear_cnt_r;
  logic wake_s1_r;
  logic wake_s2_r;
  logic wake_go;
  logic sw_write;
  logic sleeping;
  logic wdog_enable;

  assign sw_write = REG_REQ.we && (REG_REQ.addr == SLEEP_STATE_CONTROL_ADDR);
  assign sleeping = (state_r == ST_SLEEP);
  // wake comes from a pin or from software writing the select bit back to 0
  assign wake_go = sleeping && (wake_s2_r ||
                   (sw_write && !REG_REQ.wdata[HIBERNATE_BIT]));

  // wake pin is asynchronous to CLK
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= WAKE_REQUEST;
      wake_s2_r <= wake_s1_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_ACTIVE: begin
        if (hibernate_r) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_go) begin
          state_nxt = cfg_r.wake_via_startup_sel ? ST_STARTUP : ST_ACTIVE;
        end
      end
      ST_STARTUP: begin
        if (startup_cnt_r == 8'h00) begin
          state_nxt = ST_ACTIVE;
        end
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      startup_cnt_r <= 8'h00;
    end else if (state_r == ST_SLEEP && state_nxt == ST_STARTUP) begin
      startup_cnt_r <= STARTUP_CYCLES - 8'h01;
    end else if (startup_cnt_r != 8'h00) begin
      startup_cnt_r <= startup_cnt_r - 8'h01;
    end
  end

  // ==========================================================
  // control register
  // the state-select bit is cleared by the machine when it leaves hibernate,
  // so a pin wake is visible to software on readback
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hibernate_r <= 1'b0;
    end else if (wake_go) begin
      hibernate_r <= 1'b0;
    end else if (sw_write) begin
      hibernate_r <= REG_REQ.wdata[HIBERNATE_BIT];
    end
  end

  // an internal register clear also returns the hibernate options to defaults
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= sleep_cfg_t'(SLEEP_STATE_CONTROL_RESET[7:0]);
    end else if (REG_CLEAR) begin
      cfg_r <= sleep_cfg_t'(SLEEP_STATE_CONTROL_RESET[7:0]);
    end else if (sw_write) begin
      cfg_r <= sleep_cfg_t'(REG_REQ.wdata[7:0]);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_REQ.re && REG_REQ.addr == SLEEP_STATE_CONTROL_ADDR) begin
      REG_RDATA <= {hibernate_r, 7'h00, cfg_r} & SLEEP_STATE_CONTROL_MASK;
    end else if (REG_REQ.re) begin
      REG_RDATA <= 16'h0000;
    end
  end

  // ==========================================================
  // register reset pulse on wake
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      clear_cnt_r <= 4'h0;
    end else if (wake_go && !cfg_r.wake_register_clear_sel) begin
      clear_cnt_r <= REG_CLEAR_CYCLES;
    end else if (clear_cnt_r != 4'h0) begin
      clear_cnt_r <= clear_cnt_r - 4'h1;
    end
  end

  // ==========================================================
  // status outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HIBERNATING <= 1'b0;
      STARTUP_BUSY <= 1'b0;
      REG_CLEAR <= 1'b0;
    end else begin
      HIBERNATING <= sleeping;
      STARTUP_BUSY <= (state_r == ST_STARTUP);
      REG_CLEAR <= (clear_cnt_r != 4'h0);
    end
  end

  // ==========================================================
  // reset pins
  // held asserted through device reset, so nothing downstream runs
  // before this block has a configuration
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SYSRESET_OUT_N <= 1'b0;
      MEMORY_RESET_OUT_N <= 1'b0;
    end else begin
      SYSRESET_OUT_N <= sleeping ? cfg_r.sleep_sysreset_level : SYSRESET_ACTIVE_N;
      MEMORY_RESET_OUT_N <= sleeping ? cfg_r.sleep_memory_reset_level
                                     : MEMORY_RESET_ACTIVE_N;
    end
  end

  // ==========================================================
  // interrupt pin
  // the mask only hides the request; the source keeps its pending state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ_OUT_N <= 1'b1;
    end else begin
      IRQ_OUT_N <= (sleeping && cfg_r.sleep_interrupt_mask) ? 1'b1 : IRQ_PENDING_N;
    end
  end

  // ==========================================================
  // analogue keep-alive enables
  // both come out of reset on, but the keep bits reset to 0, so an unconfigured part turns both off in hibernate
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      COMPARATOR_ENABLE <= 1'b1;
      THERMAL_ENABLE <= 1'b1;
    end else begin
      COMPARATOR_ENABLE <= !sleeping || cfg_r.sleep_comparator_keep;
      THERMAL_ENABLE <= !sleeping || cfg_r.sleep_thermal_keep;
    end
  end

  // ==========================================================
  // watchdog
  assign wdog_enable = !sleeping || cfg_r.sleep_watchdog_gate;

  watchdog_action u_wdog (
    .CLK(CLK),
    .RST_N(RST_N),
    .ENABLE(wdog_enable),
    .MODE(WATCHDOG_ACTION_SELECT),
    .EXPIRE(WATCHDOG_EXPIRE),
    .EXPIRY_EVENT(WATCHDOG_EXPIRY_EVENT),
    .RESET_EVENT(WATCHDOG_RESET_EVENT)
  );
endmodule
`default_nettype wire

// *** rtl/sleep_ctrl_pkg.sv ***
// package: register map, field positions and types for the hibernate state control block
package sleep_ctrl_pkg;
  localparam logic [7:0] SLEEP_STATE_CONTROL_ADDR = 8'h05;
  localparam logic [15:0] SLEEP_STATE_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] SLEEP_STATE_CONTROL_MASK = 16'h80FF;
  localparam int HIBERNATE_BIT = 15;
  localparam int WDOG_GATE_BIT = 7;
  localparam int WAKE_STARTUP_BIT = 6;
  localparam int WAKE_CLEAR_BIT = 5;
  localparam int SYSRESET_LVL_BIT = 4;
  localparam int IRQ_MASK_BIT = 3;
  localparam int MEMRESET_LVL_BIT = 2;
  localparam int COMP_KEEP_BIT = 1;
  localparam int THERMAL_KEEP_BIT = 0;
  // length of the internal register reset pulse and of the startup sequence, in cycles
  localparam logic [3:0] REG_CLEAR_CYCLES = 4'h1;
  localparam logic [7:0] STARTUP_CYCLES = 8'h10;

  typedef enum logic [1:0] {
    WDOG_OFF = 2'h0,
    WDOG_TIMEOUT_IRQ = 2'h1,
    WDOG_WAKE_RESET = 2'h2,
    WDOG_TWO_STAGE = 2'h3
  } watchdog_mode_t;

  typedef struct packed {
    logic sleep_watchdog_gate;
    logic wake_via_startup_sel;
    logic wake_register_clear_sel;
    logic sleep_sysreset_level;
    logic sleep_interrupt_mask;
    logic sleep_memory_reset_level;
    logic sleep_comparator_keep;
    logic sleep_thermal_keep;
  } sleep_cfg_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
endpackage

// *** rtl/watchdog_action.sv ***
// watchdog expiry decoder: turns timer expiries into interrupt and reset events
`timescale 1ns/100ps
`default_nettype none
module watchdog_action (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ENABLE,
  input wire sleep_ctrl_pkg::watchdog_mode_t MODE,
  input wire logic EXPIRE,
  output logic EXPIRY_EVENT,
  output logic RESET_EVENT
);
  import sleep_ctrl_pkg::*;
  logic first_seen_r;

  // first expiry is remembered only in the two-stage mode; a disable rearms it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      first_seen_r <= 1'b0;
    end else if (!ENABLE || MODE != WDOG_TWO_STAGE) begin
      first_seen_r <= 1'b0;
    end else if (EXPIRE) begin
      first_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      EXPIRY_EVENT <= 1'b0;
      RESET_EVENT <= 1'b0;
    end else begin
      EXPIRY_EVENT <= 1'b0;
      RESET_EVENT <= 1'b0;
      if (ENABLE && EXPIRE) begin
        unique case (MODE)
          WDOG_OFF: begin
          end
          WDOG_TIMEOUT_IRQ: EXPIRY_EVENT <= 1'b1;
          WDOG_WAKE_RESET: RESET_EVENT <= 1'b1;
          WDOG_TWO_STAGE: begin
            EXPIRY_EVENT <= !first_seen_r;
            RESET_EVENT <= first_seen_r;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/hibernate_state_control_asserts.sv ***
// checker: hibernate pin levels, wake steps and watchdog gating
`timescale 1ns/100ps
`default_nettype none
module hibernate_state_control_chk
  import sleep_ctrl_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire sleep_ctrl_pkg::reg_req_t REG_REQ,
  input wire sleep_ctrl_pkg::watchdog_mode_t WATCHDOG_ACTION_SELECT,
  input wire logic HIBERNATING,
  input wire logic STARTUP_BUSY,
  input wire logic REG_CLEAR,
  input wire logic SYSRESET_OUT_N,
  input wire logic MEMORY_RESET_OUT_N,
  input wire logic IRQ_OUT_N,
  input wire logic COMPARATOR_ENABLE,
  input wire logic THERMAL_ENABLE,
  input wire logic WATCHDOG_EXPIRY_EVENT,
  input wire logic WATCHDOG_RESET_EVENT
);
  logic hit;
  logic [7:0] cfg_r;
  logic [7:0] pcfg_r;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // ========
  // config mirror, one edge later again to line up with the registered pins
  assign hit = REG_REQ.we && REG_REQ.addr == SLEEP_STATE_CONTROL_ADDR;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= 8'h00;
      pcfg_r <= 8'h00;
    end else begin
      cfg_r <= REG_CLEAR ? 8'h00 : (hit ? REG_REQ.wdata[7:0] : cfg_r);
      pcfg_r <= cfg_r;
    end
  end
  // ========
  // assertions
  sleep_entry_a: assert property (hit && REG_REQ.wdata[15] && !HIBERNATING && !STARTUP_BUSY
    |-> ##3 HIBERNATING) else $error("hibernate not entered");
  wdog_gate_a: assert property (HIBERNATING && $past(HIBERNATING) && !pcfg_r[7]
    |-> !WATCHDOG_EXPIRY_EVENT && !WATCHDOG_RESET_EVENT) else $error("watchdog not gated");
  direct_wake_a: assert property ($fell(HIBERNATING) && !pcfg_r[6] |-> !STARTUP_BUSY[*3])
    else $error("startup ran on direct wake");
  wake_clear_a: assert property ($fell(HIBERNATING) |-> REG_CLEAR == !pcfg_r[5] ##1 !REG_CLEAR)
    else $error("register clear pulse wrong");
  sleep_rst_a: assert property (HIBERNATING |-> SYSRESET_OUT_N == pcfg_r[4])
    else $error("reset level wrong in hibernate");
  irq_mask_a: assert property (HIBERNATING && pcfg_r[3] |-> IRQ_OUT_N)
    else $error("interrupt not masked");
  sleep_mem_a: assert property (HIBERNATING |-> MEMORY_RESET_OUT_N == pcfg_r[2])
    else $error("memory reset level wrong");
  comp_keep_a: assert property (HIBERNATING |-> COMPARATOR_ENABLE == pcfg_r[1])
    else $error("comparator enable wrong");
  thermal_keep_a: assert property (HIBERNATING |-> THERMAL_ENABLE == pcfg_r[0])
    else $error("thermal enable wrong");
  wdog_off_a: assert property (WATCHDOG_ACTION_SELECT == WDOG_OFF
    |=> !WATCHDOG_EXPIRY_EVENT && !WATCHDOG_RESET_EVENT) else $error("watchdog active when off");
  wake_clr_c: cover property ($fell(HIBERNATING) && REG_CLEAR);
  boot_c: cover property ($rose(STARTUP_BUSY));
  wdog_rst_c: cover property (WATCHDOG_RESET_EVENT);
endmodule
bind hibernate_state_control hibernate_state_control_chk i_hibernate_state_control_chk (
  .CLK(CLK),
  .RST_N(RST_N),
  .REG_REQ(REG_REQ),
  .WATCHDOG_ACTION_SELECT(WATCHDOG_ACTION_SELECT),
  .HIBERNATING(HIBERNATING),
  .STARTUP_BUSY(STARTUP_BUSY),
  .REG_CLEAR(REG_CLEAR),
  .SYSRESET_OUT_N(SYSRESET_OUT_N),
  .MEMORY_RESET_OUT_N(MEMORY_RESET_OUT_N),
  .IRQ_OUT_N(IRQ_OUT_N),
  .COMPARATOR_ENABLE(COMPARATOR_ENABLE),
  .THERMAL_ENABLE(THERMAL_ENABLE),
  .WATCHDOG_EXPIRY_EVENT(WATCHDOG_EXPIRY_EVENT),
  .WATCHDOG_RESET_EVENT(WATCHDOG_RESET_EVENT)
);
`default_nettype wire

// *** verification/hibernate_state_control_test.sv ***
// testbench: register access, hibernate levels, wake paths, watchdog modes
`timescale 1ns/100ps
`default_nettype none
module hibernate_state_control_test;
  import sleep_ctrl_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  reg_req_t REG_REQ = '0;
  watchdog_mode_t WATCHDOG_ACTION_SELECT = WDOG_OFF;
  logic WATCHDOG_EXPIRE = 1'b0;
  logic WAKE_REQUEST = 1'b0;
  logic IRQ_PENDING_N = 1'b1;
  logic SYSRESET_ACTIVE_N = 1'b1;
  logic MEMORY_RESET_ACTIVE_N = 1'b1;
  logic [15:0] REG_RDATA;
  logic HIBERNATING, STARTUP_BUSY, REG_CLEAR, SYSRESET_OUT_N, MEMORY_RESET_OUT_N;
  logic IRQ_OUT_N, COMPARATOR_ENABLE, THERMAL_ENABLE;
  logic WATCHDOG_EXPIRY_EVENT, WATCHDOG_RESET_EVENT;
  int n_exp = 0;
  int n_rst = 0;
  int mismatches = 0;
  int total_checks = 0;
  hibernate_state_control i_hibernate_state_control (
    .CLK(CLK),
    .RST_N(RST_N),
    .REG_REQ(REG_REQ),
    .REG_RDATA(REG_RDATA),
    .WATCHDOG_ACTION_SELECT(WATCHDOG_ACTION_SELECT),
    .WATCHDOG_EXPIRE(WATCHDOG_EXPIRE),
    .WAKE_REQUEST(WAKE_REQUEST),
    .IRQ_PENDING_N(IRQ_PENDING_N),
    .SYSRESET_ACTIVE_N(SYSRESET_ACTIVE_N),
    .MEMORY_RESET_ACTIVE_N(MEMORY_RESET_ACTIVE_N),
    .HIBERNATING(HIBERNATING),
    .STARTUP_BUSY(STARTUP_BUSY),
    .REG_CLEAR(REG_CLEAR),
    .SYSRESET_OUT_N(SYSRESET_OUT_N),
    .MEMORY_RESET_OUT_N(MEMORY_RESET_OUT_N),
    .IRQ_OUT_N(IRQ_OUT_N),
    .COMPARATOR_ENABLE(COMPARATOR_ENABLE),
    .THERMAL_ENABLE(THERMAL_ENABLE),
    .WATCHDOG_EXPIRY_EVENT(WATCHDOG_EXPIRY_EVENT),
    .WATCHDOG_RESET_EVENT(WATCHDOG_RESET_EVENT)
  );
  always #12.5 CLK = ~CLK;
  // ========
  // tallies, so a one-cycle pulse is never missed by a late sample
  always @(posedge CLK) begin
    if (WATCHDOG_EXPIRY_EVENT === 1'b1) n_exp <= n_exp + 1;
    if (WATCHDOG_RESET_EVENT === 1'b1) n_rst <= n_rst + 1;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask
  // bus strobes drop for a cycle between requests
  task wr(input logic [7:0] a, input logic [15:0] d);
    REG_REQ = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    cyc(1);
    REG_REQ = '0;
    cyc(1);
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    REG_REQ = '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
    cyc(1);
    REG_REQ = '0;
    d = REG_RDATA;
    cyc(1);
  endtask
  task pulse;
    WATCHDOG_EXPIRE = 1'b1;
    cyc(1);
    WATCHDOG_EXPIRE = 1'b0;
    cyc(3);
  endtask
  // ========
  // scenarios
  task automatic t_regs;
    logic [15:0] d;
    rd(SLEEP_STATE_CONTROL_ADDR, d);
    chk("reset", SLEEP_STATE_CONTROL_RESET, d);
    wr(SLEEP_STATE_CONTROL_ADDR, 16'h7FFF);
    rd(SLEEP_STATE_CONTROL_ADDR, d);
    chk("rsvd", 16'h00FF, d);
    wr(8'h06, 16'hFFFF);
    rd(8'h06, d);
    chk("unmap", 16'h0000, d);
    wr(SLEEP_STATE_CONTROL_ADDR, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_wdog;
    int e0;
    int r0;
    for (int m = 0; m < 4; m++) begin
      WATCHDOG_ACTION_SELECT = watchdog_mode_t'(m);
      cyc(2);
      e0 = n_exp;
      r0 = n_rst;
      repeat (2) pulse();
      chk("expiry", 16'((m == 1) ? 2 : (m == 3)), 16'(n_exp - e0));
      chk("wdreset", 16'((m == 2) ? 2 : (m == 3)), 16'(n_rst - r0));
    end
    WATCHDOG_ACTION_SELECT = WDOG_TIMEOUT_IRQ;
    $display("test watchdog done");
  endtask
  // active-side inputs are set opposite to the sleep levels so a pass-through shows
  task automatic t_sleep(input logic [7:0] c, input logic pin);
    logic [15:0] d;
    int e0;
    int nc = 0;
    int ns = 0;
    SYSRESET_ACTIVE_N = ~c[4];
    MEMORY_RESET_ACTIVE_N = ~c[2];
    IRQ_PENDING_N = 1'b0;
    wr(SLEEP_STATE_CONTROL_ADDR, {8'h80, c});
    cyc(1);
    chk("hib", 16'h0001, 16'(HIBERNATING));
    chk("rst", 16'(c[4]), 16'(SYSRESET_OUT_N));
    chk("irq", 16'(c[3]), 16'(IRQ_OUT_N));
    chk("mem", 16'(c[2]), 16'(MEMORY_RESET_OUT_N));
    chk("cmp", 16'(c[1]), 16'(COMPARATOR_ENABLE));
    chk("thm", 16'(c[0]), 16'(THERMAL_ENABLE));
    e0 = n_exp;
    pulse();
    chk("gate", 16'(c[7]), 16'(n_exp - e0));
    // the wake write is driven inline so the count sees the clear pulse right after it
    if (pin) WAKE_REQUEST = 1'b1;
    else REG_REQ = '{we: 1'b1, re: 1'b0, addr: SLEEP_STATE_CONTROL_ADDR, wdata: {8'h00, c}};
    for (int k = 0; k < 40; k++) begin
      cyc(1);
      if (k == 0) REG_REQ = '0;
      nc += (REG_CLEAR === 1'b1);
      ns += (STARTUP_BUSY === 1'b1);
    end
    WAKE_REQUEST = 1'b0;
    chk("clr", c[5] ? 16'h0000 : 16'(REG_CLEAR_CYCLES), 16'(nc));
    chk("boot", c[6] ? 16'(STARTUP_CYCLES) : 16'h0000, 16'(ns));
    chk("woke", 16'h0000, 16'(HIBERNATING));
    rd(SLEEP_STATE_CONTROL_ADDR, d);
    chk("back", c[5] ? {8'h00, c} : 16'h0000, d);
    $display("test sleep %h done", c);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    RST_N = 1'b1;
    cyc(1);
    t_regs();
    t_wdog();
    t_sleep(8'h00, 1'b0);
    t_sleep(8'hDF, 1'b0);
    t_sleep(8'h6A, 1'b1);
    t_sleep(8'hB5, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
